// ===== hw/opp_port.sv
// optical port and energy pulse output conditioning, top level
// assumes synchronous inputs, an 8-bit register port with
// read data one cycle after the read strobe
//
// Added by the designer: the strobed register port.
`default_nettype none

// What this block does
// - modulation carrier low for 50, 25, 12.5 or 6.25 percent
// - receive pin feeds serial comparator path, or general I/O one when disabled
// - receive inversion affects only serial receiver, not general I/O input
// - transmit source: serial, general I/O two, energy pulse; 11 reserved
// - transmit inversion applied before modulation
// - modulation replaces zero transmit level with carrier, passes ones
// - energy pulse width capped at (2N+1) times T1; N=255 disables it in bypass, gives one T1 when queued
// - nonzero spacing uses pulse queue; zero bypasses, pulses immediate
// - energy pulse active low, active high when polarity bit set
module opp_port #(
  parameter int SAMPLE_CYC  = opp_pkg::OPP_SAMPLE_CYC,
  parameter int CARRIER_DIV = opp_pkg::OPP_CARRIER_DIV
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [7:0]       rdata,
  input  wire logic        uart_txd,
  input  wire logic        general_io_two,
  input  wire logic        ce_pulse,
  input  wire logic        optical_receive_pin,
  output logic             optical_transmit_pin,
  output logic             uart_rxd,
  output logic             general_io_one,
  output logic             energy_pulse_out
);
  // configuration registers
  logic       pulse_polarity_bit;
  logic [1:0] optical_duty_select;
  logic [1:0] optical_tx_source_select;
  logic       optical_tx_invert;
  logic       optical_tx_modulate_enable;
  logic       optical_rx_invert;
  logic       optical_rx_as_gpio;
  logic [7:0] pulse_width_cap;
  logic [7:0] pulse_spacing_setting;
  // internal signals
  logic       carrier;
  logic       pulse_active;
  logic       pulse_queued;
  logic       pulse_capped;
  logic       pulse_level;
  logic       tx_src;
  logic       tx_pre;
  logic       next_tx;
  logic [7:0] next_rdata;

  // carrier generator
  opp_carrier #(
    .DIV(CARRIER_DIV)
  ) u_carrier (
    .clk    (clk),
    .rstn   (rstn),
    .clk_en (clk_en),
    .duty   (optical_duty_select),
    .carrier(carrier)
  );

  // energy pulse shaper
  opp_pulse #(
    .SAMPLE_CYC(SAMPLE_CYC),
    .UNIT_CYC  (opp_pkg::OPP_UNIT_CYC)
  ) u_pulse (
    .clk     (clk),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .cap     (pulse_width_cap),
    .spacing (pulse_spacing_setting),
    .ce_pulse(ce_pulse),
    .active  (pulse_active),
    .queued  (pulse_queued),
    .capped  (pulse_capped)
  );

  // register writes; bits of other blocks in shared bytes are ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulse_polarity_bit         <= 1'b0;
      optical_duty_select        <= opp_pkg::OPP_DUTY_RST;
      optical_tx_source_select   <= opp_pkg::OPP_TXSRC_RST;
      optical_tx_invert          <= 1'b0;
      optical_tx_modulate_enable <= 1'b0;
      optical_rx_invert          <= 1'b0;
      optical_rx_as_gpio         <= 1'b0;
      pulse_width_cap            <= opp_pkg::OPP_CAP_RST;
      pulse_spacing_setting      <= opp_pkg::OPP_SPACING_RST;
    end else if (clk_en && wr_stb) begin
      case (addr)
        opp_pkg::OPP_ADDR_PULSE_POL: begin
          pulse_polarity_bit <= wdata[opp_pkg::OPP_POL_BIT];
        end
        opp_pkg::OPP_ADDR_TX_CFG: begin
          optical_tx_source_select <= wdata[opp_pkg::OPP_TXSRC_LSB +: 2];
          optical_duty_select      <= wdata[opp_pkg::OPP_DUTY_LSB +: 2];
        end
        opp_pkg::OPP_ADDR_PORT_CFG: begin
          optical_tx_invert          <= wdata[opp_pkg::OPP_TXINV_BIT];
          optical_tx_modulate_enable <= wdata[opp_pkg::OPP_TXMOD_BIT];
          optical_rx_invert          <= wdata[opp_pkg::OPP_RXINV_BIT];
          optical_rx_as_gpio         <= wdata[opp_pkg::OPP_RXGPIO_BIT];
        end
        opp_pkg::OPP_ADDR_WIDTH_CAP: begin
          pulse_width_cap <= wdata;
        end
        opp_pkg::OPP_ADDR_SPACING: begin
          pulse_spacing_setting <= wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // read decode; unmapped addresses and unused bits read as zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      opp_pkg::OPP_ADDR_PULSE_POL: begin
        next_rdata[opp_pkg::OPP_POL_BIT] = pulse_polarity_bit;
      end
      opp_pkg::OPP_ADDR_TX_CFG: begin
        next_rdata[opp_pkg::OPP_TXSRC_LSB +: 2] = optical_tx_source_select;
        next_rdata[opp_pkg::OPP_DUTY_LSB +: 2]  = optical_duty_select;
      end
      opp_pkg::OPP_ADDR_PORT_CFG: begin
        next_rdata[opp_pkg::OPP_TXINV_BIT]  = optical_tx_invert;
        next_rdata[opp_pkg::OPP_TXMOD_BIT]  = optical_tx_modulate_enable;
        next_rdata[opp_pkg::OPP_RXINV_BIT]  = optical_rx_invert;
        next_rdata[opp_pkg::OPP_RXGPIO_BIT] = optical_rx_as_gpio;
      end
      opp_pkg::OPP_ADDR_WIDTH_CAP: begin
        next_rdata = pulse_width_cap;
      end
      opp_pkg::OPP_ADDR_SPACING: begin
        next_rdata = pulse_spacing_setting;
      end
      opp_pkg::OPP_ADDR_STATUS: begin
        next_rdata[opp_pkg::OPP_ST_ACTIVE] = pulse_active;
        next_rdata[opp_pkg::OPP_ST_QUEUED] = pulse_queued;
        next_rdata[opp_pkg::OPP_ST_CAPPED] = pulse_capped;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata <= 8'h00;
    else if (clk_en) rdata <= rd_stb ? next_rdata : 8'h00;
  end

  // energy pulse level before polarity: low while active
  assign pulse_level = !pulse_active;

  // transmit source select
  always_comb begin
    case (optical_tx_source_select)
      opp_pkg::OPP_TX_SERIAL: tx_src = uart_txd;
      opp_pkg::OPP_TX_GPIO2:  tx_src = general_io_two;
      opp_pkg::OPP_TX_PULSE:  tx_src = pulse_polarity_bit ? !pulse_level : pulse_level;
      default:                tx_src = 1'b1;  // reserved: idle high
    endcase
  end

  // inversion first, then carrier replaces a zero level
  assign tx_pre  = tx_src ^ optical_tx_invert;
  assign next_tx = (optical_tx_modulate_enable && !tx_pre) ? carrier : tx_pre;

  // transmit pin register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) optical_transmit_pin <= 1'b1;
    else if (clk_en) optical_transmit_pin <= next_tx;
  end

  // receive routing: serial path with optional inversion, or general I/O one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uart_rxd       <= 1'b1;
      general_io_one <= 1'b0;
    end else if (clk_en) begin
      uart_rxd       <= optical_rx_as_gpio ? 1'b1 : (optical_receive_pin ^ optical_rx_invert);
      general_io_one <= optical_rx_as_gpio ? optical_receive_pin : 1'b0;
    end
  end

  // energy pulse pin with selectable polarity
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) energy_pulse_out <= 1'b1;
    else if (clk_en) energy_pulse_out <= pulse_polarity_bit ? pulse_active : !pulse_active;
  end

  a_rx_serial_path: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && !optical_rx_as_gpio |=> uart_rxd == $past(optical_receive_pin ^ optical_rx_invert))
    else $error("serial receive path wrong");
  a_rx_gpio_path: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && optical_rx_as_gpio |=> general_io_one == $past(optical_receive_pin) && uart_rxd)
    else $error("general I/O receive path wrong");
  a_tx_serial_select: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && optical_tx_source_select == 2'h0 && !optical_tx_invert && !optical_tx_modulate_enable
    |=> optical_transmit_pin == $past(uart_txd))
    else $error("serial transmit not routed");
  a_tx_gpio_invert: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && optical_tx_source_select == 2'h1 && optical_tx_invert && !optical_tx_modulate_enable
    |=> optical_transmit_pin == !$past(general_io_two))
    else $error("transmit inversion wrong");
  a_tx_modulate_zero: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && optical_tx_modulate_enable |=> optical_transmit_pin == ($past(tx_pre) ? 1'b1 : $past(carrier)))
    else $error("modulation stage wrong");
  a_pulse_polarity_out: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && pulse_active |=> energy_pulse_out == $past(pulse_polarity_bit))
    else $error("energy pulse polarity wrong");
endmodule
`default_nettype wire

// ===== hw/opp_pkg.sv
// constants for the optical port and energy pulse block
// assumes an 8-bit register port and a 50 MHz system clock
`default_nettype none
package opp_pkg;
  // register addresses on the plain register port
  localparam logic [15:0] OPP_ADDR_PULSE_POL = 16'h2004;
  localparam logic [15:0] OPP_ADDR_TX_CFG    = 16'h2007;
  localparam logic [15:0] OPP_ADDR_PORT_CFG  = 16'h2008;
  localparam logic [15:0] OPP_ADDR_WIDTH_CAP = 16'h2080;
  localparam logic [15:0] OPP_ADDR_SPACING   = 16'h2081;
  localparam logic [15:0] OPP_ADDR_STATUS    = 16'h2082;
  // field positions
  localparam int OPP_POL_BIT    = 6;
  localparam int OPP_TXSRC_LSB  = 6;
  localparam int OPP_DUTY_LSB   = 0;
  localparam int OPP_TXINV_BIT  = 0;
  localparam int OPP_TXMOD_BIT  = 1;
  localparam int OPP_RXINV_BIT  = 4;
  localparam int OPP_RXGPIO_BIT = 5;
  localparam int OPP_ST_ACTIVE  = 0;
  localparam int OPP_ST_QUEUED  = 1;
  localparam int OPP_ST_CAPPED  = 2;
  // reset values
  localparam logic [1:0] OPP_TXSRC_RST   = 2'h0;
  localparam logic [1:0] OPP_DUTY_RST    = 2'h0;
  localparam logic [7:0] OPP_CAP_RST     = 8'hFF;
  localparam logic [7:0] OPP_SPACING_RST = 8'h00;
  // transmit source codes
  localparam logic [1:0] OPP_TX_SERIAL = 2'h0;
  localparam logic [1:0] OPP_TX_GPIO2  = 2'h1;
  localparam logic [1:0] OPP_TX_PULSE  = 2'h2;
  // width cap value that removes the cap in bypass mode; queued pulses then last one T1
  localparam logic [7:0] OPP_CAP_OFF = 8'hFF;
  // timing
  localparam int OPP_CLK_MHZ    = 50;
  localparam int OPP_SAMPLE_NS  = 397000;
  localparam int OPP_SAMPLE_CYC = (OPP_SAMPLE_NS * OPP_CLK_MHZ) / 1000;
  localparam int OPP_UNIT_CYC   = 20;
  localparam int OPP_CARRIER_DIV = 16;
  localparam int OPP_QUEUE_W    = 4;
  // pulse shaper states
  typedef enum logic [1:0] {OPP_P_IDLE, OPP_P_ACTIVE, OPP_P_HELD} opp_pstate_t;
endpackage
`default_nettype wire

// ===== hw/opp_carrier.sv
// modulation carrier with selectable low fraction
// assumes clk_en freezes the divider
`default_nettype none
module opp_carrier #(
  parameter int DIV = opp_pkg::OPP_CARRIER_DIV
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic [1:0] duty,
  output logic            carrier
);
  logic [7:0] cnt;
  logic [7:0] low_len;

  // low run is the period divided by 2, 4, 8 or 16
  // shift count kept 3 bits wide so that duty 11 shifts by four, not by zero
  assign low_len = 8'(DIV) >> (3'(duty) + 3'h1);

  // period counter from a fixed divider of the system clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
    end else if (clk_en) begin
      cnt <= (cnt == 8'(DIV - 1)) ? 8'h00 : cnt + 8'h01;
    end
  end

  // low for the first low_len cycles of each period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carrier <= 1'b1;
    end else if (clk_en) begin
      carrier <= (cnt >= low_len);
    end
  end

  a_carrier_low_start: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && cnt == 8'h00 && low_len != 8'h00 |=> !carrier)
    else $error("carrier not low at period start");
  a_carrier_high_end: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && cnt == 8'(DIV - 1) |=> carrier)
    else $error("carrier not high at period end");
endmodule
`default_nettype wire

// ===== hw/opp_pulse.sv
// energy pulse shaper: width cap, spacing queue, bypass
// assumes ce_pulse is the compute engine pulse, high while asserted
`default_nettype none
module opp_pulse #(
  parameter int SAMPLE_CYC = opp_pkg::OPP_SAMPLE_CYC,
  parameter int UNIT_CYC   = opp_pkg::OPP_UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic [7:0] cap,
  input  wire logic [7:0] spacing,
  input  wire logic       ce_pulse,
  output logic            active,
  output logic            queued,
  output logic            capped
);
  opp_pkg::opp_pstate_t state;
  opp_pkg::opp_pstate_t next_state;
  logic [15:0] t1_cnt;
  logic [15:0] t1_len;
  logic        t1_tick;
  logic [8:0]  w_cnt;
  logic [8:0]  cap_len;
  logic        ce_q;
  logic [opp_pkg::OPP_QUEUE_W-1:0] q_cnt;
  logic        bypass;
  logic        start;
  logic        push;

  assign bypass  = (spacing == 8'h00);
  // T1 is the sample time or the spacing setting
  assign t1_len  = bypass ? 16'(SAMPLE_CYC - 1) : 16'(int'(spacing) * UNIT_CYC - 1);
  assign t1_tick = (t1_cnt == 16'h0000);
  assign cap_len = {cap, 1'b1};  // 2N+1
  assign push    = !bypass && ce_pulse && !ce_q && (q_cnt != '1);
  assign start   = (state == opp_pkg::OPP_P_IDLE) && (next_state == opp_pkg::OPP_P_ACTIVE);
  assign active  = (state == opp_pkg::OPP_P_ACTIVE);
  assign queued  = (q_cnt != '0);
  assign capped  = (state == opp_pkg::OPP_P_HELD);

  // shaper next state
  always_comb begin
    next_state = state;
    case (state)
      opp_pkg::OPP_P_IDLE: begin
        if (bypass ? ce_pulse : (queued && t1_tick)) next_state = opp_pkg::OPP_P_ACTIVE;
      end
      opp_pkg::OPP_P_ACTIVE: begin
        if (bypass) begin
          if (!ce_pulse) next_state = opp_pkg::OPP_P_IDLE;
          else if (cap != opp_pkg::OPP_CAP_OFF && t1_tick && w_cnt == cap_len - 9'h001)
            next_state = opp_pkg::OPP_P_HELD;
        end else if (t1_tick && (cap == opp_pkg::OPP_CAP_OFF || w_cnt == cap_len - 9'h001)) begin
          next_state = opp_pkg::OPP_P_IDLE;
        end
      end
      opp_pkg::OPP_P_HELD: begin
        if (!ce_pulse || !bypass) next_state = opp_pkg::OPP_P_IDLE;
      end
      default: next_state = opp_pkg::OPP_P_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state <= opp_pkg::OPP_P_IDLE;
    else if (clk_en) state <= next_state;
  end

  // T1 interval timer, realigned at each pulse start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) t1_cnt <= 16'h0000;
    else if (clk_en) t1_cnt <= (t1_tick || start) ? t1_len : t1_cnt - 16'h0001;
  end

  // width counter in T1 units
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) w_cnt <= 9'h000;
    else if (clk_en) begin
      if (start) w_cnt <= 9'h000;
      else if (active && t1_tick) w_cnt <= w_cnt + 9'h001;
    end
  end

  // pulse queue: rising edges in, one out per spaced pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ce_q  <= 1'b0;
      q_cnt <= '0;
    end else if (clk_en) begin
      ce_q <= ce_pulse;
      if (bypass) q_cnt <= '0;
      else q_cnt <= q_cnt + (push ? 1'b1 : 1'b0) - ((start && !bypass) ? 1'b1 : 1'b0);
    end
  end

  a_width_cap_hold: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && active && bypass && ce_pulse && cap != 8'hFF && t1_tick && w_cnt == cap_len - 9'h001
    |=> capped && !active)
    else $error("pulse not cut at width cap");
  a_bypass_immediate: assert property (@(posedge clk) disable iff (!rstn)
    clk_en && bypass && state == opp_pkg::OPP_P_IDLE && ce_pulse |=> active)
    else $error("bypassed pulse delayed");
endmodule
`default_nettype wire

// ===== hw/opp_dummy_unused.sv
// no logic: this file holds no module
// assumes nothing of its surroundings
`default_nettype none
`default_nettype wire

// ===== test/opp_ir_xcvr.sv
// infrared transceiver model facing the optical transmit and receive pins
// assumes tb commands the light level seen and opens a measuring window on tx
`default_nettype none
module opp_ir_xcvr #(
  parameter int LAG = 2
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        tx_pin,
  input  wire logic        light,
  input  wire logic        meas,
  output logic             rx_pin,
  output logic [15:0]      low_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lag_sh;

  // detector responds slowly: commanded light reaches the comparator after LAG+1 cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lag_sh <= 4'hF;
      rx_pin <= 1'b1;
    end else begin
      lag_sh <= {lag_sh[2:0], light};
      rx_pin <= lag_sh[LAG-1];
    end
  end

  // emitter side: count cycles with the led driven low inside the window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 16'h0000;
    end else if (!meas) begin
      low_cnt <= 16'h0000;
    end else if (!tx_pin) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the optical port and energy pulse block
// assumes 50 MHz clock and shortened sample time; clock enable dropped once
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, clk_en = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        uart_txd = 1'b1, general_io_two = 1'b1, ce_pulse = 1'b0, light = 1'b1, meas = 1'b0;
  logic        rx_pin, tx_pin, uart_rxd, general_io_one, energy_pulse_out;
  logic [15:0] low_cnt;
  int          fail_count = 0, n_tests = 0;
  logic [1:0]  src;
  logic        exp;

  // clock generator
  always #10 clk = ~clk;

  opp_port #(.SAMPLE_CYC(20), .CARRIER_DIV(16)) uut (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .uart_txd(uart_txd),
    .general_io_two(general_io_two), .ce_pulse(ce_pulse), .optical_receive_pin(rx_pin),
    .optical_transmit_pin(tx_pin), .uart_rxd(uart_rxd), .general_io_one(general_io_one),
    .energy_pulse_out(energy_pulse_out));

  opp_ir_xcvr #(.LAG(2)) ir (
    .clk(clk), .rstn(rstn), .tx_pin(tx_pin), .light(light), .meas(meas),
    .rx_pin(rx_pin), .low_cnt(low_cnt));

  // comparison helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    n_tests++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] want);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, want});
  endtask

  // emitter low cycles over a 64-cycle window
  task automatic measure(input logic [15:0] want);
    repeat (20) @(posedge clk);
    meas <= 1'b1;
    repeat (64) @(posedge clk);
    meas <= 1'b0;
    #1 chk(low_cnt, want);
  endtask

  // energy pulse: wait for active level, count its width, then let ce settle
  task automatic pulse(input int ce_len, input int max_wait, input logic act,
                       input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] w;
    int          k;
    w = 16'h0000;
    k = 0;
    @(posedge clk);
    ce_pulse <= 1'b1;
    fork
      begin
        repeat (ce_len) @(posedge clk);
        ce_pulse <= 1'b0;
      end
    join_none
    while (energy_pulse_out !== act && k < max_wait) begin
      @(posedge clk);
      #1 k++;
    end
    chk_rng(k[15:0], 16'h0001, max_wait[15:0]);
    while (energy_pulse_out === act && w < 16'hFFFF) begin
      @(posedge clk);
      #1 w++;
    end
    chk_rng(w, lo, hi);
    wait (ce_pulse == 1'b0);
    repeat (5) @(posedge clk);
  endtask

  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog reckoned from roughly 5k cycles of tests
  initial begin
    #(20 * 60000);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // reset values, read-back, unmapped address
    rd(opp_pkg::OPP_ADDR_PULSE_POL, 8'h00);
    rd(opp_pkg::OPP_ADDR_TX_CFG, 8'h00);
    rd(opp_pkg::OPP_ADDR_PORT_CFG, 8'h00);
    rd(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'hFF);
    rd(opp_pkg::OPP_ADDR_SPACING, 8'h00);
    wr(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'h5A);
    rd(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'h5A);
    wr(16'h2010, 8'hA5);
    rd(16'h2010, 8'h00);
    // clock enable low freezes the transmit pin, release lets it follow
    @(posedge clk);
    clk_en <= 1'b0;
    uart_txd <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, tx_pin}, 16'h0001);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, tx_pin}, 16'h0000);
    uart_txd <= 1'b1;
    // transmit source and inversion, every code
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < 2; i++) begin
        for (int v = 0; v < 2; v++) begin
          src = s[1:0];
          wr(opp_pkg::OPP_ADDR_TX_CFG, {src, 6'h00});
          wr(opp_pkg::OPP_ADDR_PORT_CFG, {7'h00, i[0]});
          uart_txd <= v[0];
          general_io_two <= ~v[0];
          repeat (3) @(posedge clk);
          exp = (src == 2'h0) ? v[0] : (src == 2'h1) ? ~v[0] : 1'b1;
          #1 chk({15'h0000, tx_pin}, {15'h0000, exp ^ i[0]});
        end
      end
    end
    // carrier duty for every code, ones pass unchanged
    wr(opp_pkg::OPP_ADDR_PORT_CFG, 8'h02);
    uart_txd <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(opp_pkg::OPP_ADDR_TX_CFG, d[7:0]);
      measure(16'd64 >> (d + 1));
    end
    uart_txd <= 1'b1;
    measure(16'h0000);
    wr(opp_pkg::OPP_ADDR_PORT_CFG, 8'h03);
    measure(16'h0004);
    uart_txd <= 1'b0;
    measure(16'h0000);
    // receive path: serial with and without inversion, then general I/O
    for (int c = 0; c < 3; c++) begin
      wr(opp_pkg::OPP_ADDR_PORT_CFG, (c == 0) ? 8'h00 : (c == 1) ? 8'h10 : 8'h30);
      for (int v = 0; v < 2; v++) begin
        light <= v[0];
        repeat (6) @(posedge clk);
        #1 chk({14'h0000, uart_rxd, general_io_one},
               (c == 2) ? {14'h0000, 1'b1, v[0]} : {14'h0000, v[0] ^ (c == 1), 1'b0});
      end
    end
    // energy pulse, bypass mode with sample time of 20 cycles
    wr(opp_pkg::OPP_ADDR_PORT_CFG, 8'h00);
    wr(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'hFF);
    pulse(100, 3, 1'b0, 16'd99, 16'd101);
    wr(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'h00);
    pulse(100, 3, 1'b0, 16'd20, 16'd22);
    // held after the cap while the source stays high: status shows capped only
    ce_pulse <= 1'b1;
    repeat (30) @(posedge clk);
    rd(opp_pkg::OPP_ADDR_STATUS, 8'h01 << opp_pkg::OPP_ST_CAPPED);
    ce_pulse <= 1'b0;
    repeat (5) @(posedge clk);
    wr(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'h01);
    pulse(100, 3, 1'b0, 16'd60, 16'd62);
    // pulse routed to the transmit pin idles high
    wr(opp_pkg::OPP_ADDR_TX_CFG, 8'h80);
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, tx_pin}, 16'h0001);
    // inverted polarity: idle low, active high
    wr(opp_pkg::OPP_ADDR_PULSE_POL, 8'h40);
    wr(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'hFF);
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, energy_pulse_out}, 16'h0000);
    pulse(30, 3, 1'b1, 16'd29, 16'd31);
    // queued mode: spacing 81 gives T1 of 1620 cycles, cap 0 gives one T1
    wr(opp_pkg::OPP_ADDR_PULSE_POL, 8'h00);
    wr(opp_pkg::OPP_ADDR_WIDTH_CAP, 8'h00);
    wr(opp_pkg::OPP_ADDR_SPACING, 8'd81);
    rd(opp_pkg::OPP_ADDR_SPACING, 8'd81);
    pulse(5, 1700, 1'b0, 16'd1620, 16'd1622);
    final_report();
  end
endmodule
`default_nettype wire
